/* File: rtl/lmdsc_pkg.sv */
// shared constants for the multiplexed led display scanner
package lmdsc_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SCAN_HZ = 6000;
    localparam int unsigned SCAN_PULSE_NS = 40_000;
    // shortest-time rounding: whole cycles, rounded down
    localparam int unsigned SCAN_CYC_DEF = CLK_HZ / SCAN_HZ;
    localparam int unsigned SCAN_PULSE_CYC_DEF = SCAN_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 16;

    localparam int unsigned NUM_STATES = 13;
    localparam int unsigned NUM_DIGITS = 11;
    localparam int unsigned NUM_COLS = 13;
    localparam logic [3:0] LAST_STATE = 4'hc;

    localparam int unsigned RAM_WORDS = 16;
    localparam int unsigned RAM_AW = 4;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned CODE_W = 8;

    localparam logic [4:0] DIG_BLANK_CODE = 5'h10;
    localparam logic [2:0] ANN_BLANK_CODE = 3'h7;
    localparam logic [2:0] ANN_IDLE_CODE = 3'h0;
    localparam logic [3:0] ANN_BASE_STATE = 4'ha;

    // data bit lanes: low nibble a,b,c,d ; high nibble e,f,g,dp
    localparam int unsigned LO_NIB_LSB = 0;
    localparam int unsigned HI_NIB_LSB = 4;

endpackage : lmdsc_pkg

/* File: rtl/lmdsc_ram_if.sv */
// display memory access bundle between scanner and memory
`timescale 1ns/1ps
interface lmdsc_ram_if;
    import lmdsc_pkg::*;
    logic we;
    logic [RAM_AW-1:0] addr;
    logic [CODE_W-1:0] wdata;
    logic [CODE_W-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : lmdsc_ram_if

/* File: rtl/lmdsc_dram.sv */
// two 16x4 display memories sharing one address
`timescale 1ns/1ps
module lmdsc_dram
    import lmdsc_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic srst_i,    // sync reset, active high
    lmdsc_ram_if.mem ram        // memory port
);

    logic [NIB_W-1:0] mem_lo [RAM_WORDS];
    logic [NIB_W-1:0] mem_hi [RAM_WORDS];

    // cleared on system reset so scan never reads unknown codes
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                mem_lo[i] <= '0;
                mem_hi[i] <= '0;
            end
        end else if (ram.we) begin
            mem_lo[ram.addr] <= ram.wdata[LO_NIB_LSB +: NIB_W];
            mem_hi[ram.addr] <= ram.wdata[HI_NIB_LSB +: NIB_W];
        end
    end

    assign ram.rdata = {mem_hi[ram.addr], mem_lo[ram.addr]};

    ////////////////////////////////////////////////////////////////////////////
    chk_hi_nibble_lane: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        ram.we ##1 ($past(ram.addr) == ram.addr)
            |-> ram.rdata[HI_NIB_LSB +: NIB_W] == $past(ram.wdata[HI_NIB_LSB +: NIB_W])
    ) else $error("upper nibble not stored from data bits 4..7");

endmodule : lmdsc_dram

/* File: rtl/lmdsc_top.sv */
// multiplexed led display scanner: scan clock, column scan, display memory, key irq
// Operation
// - A free-running scan clock near 6 kHz is produced with a high pulse of about 40 us.
// - A state counter steps through 13 states and wraps to zero, 11 digits then 2 annunciators.
// - While display reset is low the decoders get codes 16 and 7, so every column is blank.
// - A segment lights only while its drive line is low.
// - Codes sit in two sixteen-word 4-bit memories sharing one address, giving 8-bit codes.
// - With the write strobe high the processor address is used and its data byte is stored.
// - With the write strobe low the scan counter addresses memory and locations show in turn.
// - Data bits 0..3 carry segments a..d to the low memory, bits 4..7 e,f,g,dp to the high one.
// - In the thirteenth state the annunciator column shows the code stored for that location.
// - A key press raises an interrupt request to the processor.
`timescale 1ns/1ps
module lmdsc_top
    import lmdsc_pkg::*;
#(
    parameter int unsigned SCAN_CYC = SCAN_CYC_DEF,
    parameter int unsigned SCAN_PULSE_CYC = SCAN_PULSE_CYC_DEF
) (
    input wire logic sys_clk_i,                   // system clock, 125 MHz
    input wire logic srst_i,                      // sync reset, active high
    input wire logic display_reset_n_i,           // display reset, active low
    input wire logic display_write_strobe_i,      // processor write strobe, high writes
    input wire logic [RAM_AW-1:0] cpu_addr_i,     // processor address
    input wire logic [CODE_W-1:0] cpu_data_i,     // processor data
    input wire logic key_press_i,                 // key detected, high
    input wire logic kbd_read_i,                  // keyboard read, clears irq
    output logic scan_clk_o,                      // scan clock out
    output logic [NUM_COLS-1:0] col_sel_n_o,      // column selects, active low
    output logic [CODE_W-1:0] seg_n_o,            // segment drives, low lights
    output logic irq_o                            // interrupt request, high
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic scan_clk;
        logic [3:0] state;
        logic [4:0] dig_code;
        logic [2:0] ann_code;
        logic [NUM_COLS-1:0] col_n;
        logic [CODE_W-1:0] seg_n;
        logic key_d;
        logic irq;
    } lmdsc_st_t;

    lmdsc_st_t st_r;
    lmdsc_st_t st_nxt;
    logic tick;
    logic run;

    lmdsc_ram_if ram_if ();

    lmdsc_dram u_dram (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ram(ram_if.mem)
    );

    // two decoders: digit code 0..10, annunciator code 1..2; others blank
    function automatic logic [NUM_COLS-1:0] col_decode(input logic [4:0] dig,
                                                       input logic [2:0] ann);
        logic [NUM_COLS-1:0] sel;
        sel = '1;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            if (dig == 5'(i)) begin
                sel[i] = 1'b0;
            end
        end
        for (int j = 1; j <= NUM_COLS - NUM_DIGITS; j++) begin
            if (ann == 3'(j)) begin
                sel[NUM_DIGITS + j - 1] = 1'b0;
            end
        end
        return sel;
    endfunction : col_decode

    ////////////////////////////////////////////////////////////////////////////
    // memory address mux
    always_comb begin
        ram_if.we = display_write_strobe_i;
        ram_if.wdata = cpu_data_i;
        if (display_write_strobe_i) begin
            ram_if.addr = cpu_addr_i;
        end else begin
            ram_if.addr = st_r.state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // advance only on a real scan clock rise, not on the reset value of the divider
    assign tick = (st_r.div == '0) && st_r.scan_clk;
    assign run = display_reset_n_i;

    always_comb begin
        st_nxt = st_r;
        // free-running divider, pulse high at start of each period
        if (st_r.div == DIV_W'(SCAN_CYC - 1)) begin
            st_nxt.div = '0;
        end else begin
            st_nxt.div = st_r.div + DIV_W'(1);
        end
        // first pulse waits for a divider wrap, so no short pulse after reset
        st_nxt.scan_clk = (st_nxt.div < DIV_W'(SCAN_PULSE_CYC))
                          && (st_r.scan_clk || st_nxt.div == '0);
        if (tick && run) begin
            if (st_r.state == LAST_STATE) begin
                st_nxt.state = '0;
            end else begin
                st_nxt.state = st_r.state + 4'h1;
            end
        end
        if (!run) begin
            st_nxt.dig_code = DIG_BLANK_CODE;
            st_nxt.ann_code = ANN_BLANK_CODE;
        end else if (st_r.state > ANN_BASE_STATE) begin
            st_nxt.dig_code = DIG_BLANK_CODE;
            st_nxt.ann_code = 3'(st_r.state - ANN_BASE_STATE);
        end else begin
            st_nxt.dig_code = {1'b0, st_r.state};
            st_nxt.ann_code = ANN_IDLE_CODE;
        end
        st_nxt.col_n = col_decode(st_r.dig_code, st_r.ann_code);
        st_nxt.seg_n = ~ram_if.rdata;
        st_nxt.key_d = key_press_i;
        // set wins over the keyboard-read clear
        if (key_press_i && !st_r.key_d) begin
            st_nxt.irq = 1'b1;
        end else if (kbd_read_i) begin
            st_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r <= '{div: '0, scan_clk: 1'b0, state: '0, dig_code: DIG_BLANK_CODE,
                      ann_code: ANN_BLANK_CODE, col_n: '1, seg_n: '1,
                      key_d: 1'b0, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scan_clk_o = st_r.scan_clk;
    assign col_sel_n_o = st_r.col_n;
    assign seg_n_o = st_r.seg_n;
    assign irq_o = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    chk_scan_period: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        $rose(scan_clk_o) |-> $past(st_r.div) == DIV_W'(SCAN_CYC - 1)
    ) else $error("scan clock rose away from period end");

    chk_state_wrap: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (st_r.state <= LAST_STATE)
        and ((st_r.state == LAST_STATE && tick && run) |=> st_r.state == 4'h0)
    ) else $error("scan state left the 13-state range");

    chk_reset_blank: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !display_reset_n_i [*2] |=> col_sel_n_o == '1
    ) else $error("column selected during display reset");

    chk_one_column: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        $onehot0(~col_sel_n_o)
    ) else $error("more than one column selected");

    chk_seg_low_lit: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        ##1 seg_n_o == ~$past(ram_if.rdata)
    ) else $error("segment drive not inverse of stored code");

    chk_cpu_addr: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        display_write_strobe_i |-> ram_if.we && ram_if.addr == cpu_addr_i
    ) else $error("write strobe did not select processor address");

    chk_scan_addr: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !display_write_strobe_i |-> !ram_if.we && ram_if.addr == st_r.state
    ) else $error("scan did not address display memory");

    chk_ann_column: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (st_r.state == LAST_STATE && run) [*2] |=> !col_sel_n_o[NUM_COLS - 1]
    ) else $error("annunciator column not selected in state 12");

    chk_key_irq: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        (key_press_i && !st_r.key_d) |=> irq_o
    ) else $error("key press did not raise interrupt");

    chk_hold_reset: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !display_reset_n_i |=> $stable(st_r.state)
    ) else $error("scan counter moved during display reset");

endmodule : lmdsc_top

/* File: dv/lmdsc_host.sv */
// host processor model writing the display memory
`timescale 1ns/1ps
module lmdsc_host
    import lmdsc_pkg::*;
(
    input wire logic sys_clk_i,       // system clock
    output logic wr_o,                // display write strobe
    output logic [RAM_AW-1:0] addr_o, // write address
    output logic [CODE_W-1:0] data_o  // segment byte, a..d low, e..dp high
);
    initial begin
        wr_o = 1'b0;
        addr_o = 4'h0;
        data_o = 8'h00;
    end
    // call just after a rising edge; strobe held for 1 + slow edges
    task automatic wr(input logic [RAM_AW-1:0] a, input logic [CODE_W-1:0] d, input int slow);
        wr_o <= 1'b1;
        addr_o <= a;
        data_o <= d;
        repeat (1 + slow) @(posedge sys_clk_i);
        wr_o <= 1'b0;
        // released bus does not keep its last value
        addr_o <= ~a;
        data_o <= ~d;
    endtask : wr
endmodule : lmdsc_host

/* File: dv/lmdsc_bench.sv */
// self-checking bench for the led display scanner
`timescale 1ns/1ps
module lmdsc_bench;
    import lmdsc_pkg::*;
    localparam int SC = 20;
    localparam int SP = 5;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic dr_n = 1'b1;
    logic key = 1'b0;
    logic rd = 1'b0;
    logic wr, sclk, irq;
    logic sclk_q = 1'b0, wr_d1 = 1'b0, wr_d2 = 1'b0;
    logic [RAM_AW-1:0] addr, a_d1, a_d2;
    logic [CODE_W-1:0] data, seg_n;
    logic [CODE_W-1:0] seg_q = 8'hff;
    logic [NUM_COLS-1:0] col_n;
    logic [CODE_W-1:0] shadow [RAM_WORDS] = '{default: '0};
    logic [31:0] lfsr = 32'hc94ca6eb;
    int error_cnt = 0, n_checks = 0, last_col = -1;
    int qcnt = 0, on_cnt = 0, off_cnt = 0, per_cnt = -1, hi_cnt = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    lmdsc_host host (.sys_clk_i(sys_clk_i), .wr_o(wr), .addr_o(addr), .data_o(data));
    lmdsc_top #(.SCAN_CYC(SC), .SCAN_PULSE_CYC(SP)) DUT (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .display_reset_n_i(dr_n), .display_write_strobe_i(wr),
        .cpu_addr_i(addr), .cpu_data_i(data), .key_press_i(key), .kbd_read_i(rd),
        .scan_clk_o(sclk), .col_sel_n_o(col_n), .seg_n_o(seg_n), .irq_o(irq));

    ////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    function automatic logic [CODE_W-1:0] exp_seg(input int a);
        return ~shadow[a];
    endfunction : exp_seg
    // index of the one low select, -1 none, -2 several
    function automatic int col_idx(input logic [NUM_COLS-1:0] c);
        int k;
        k = -1;
        for (int i = 0; i < NUM_COLS; i++) begin
            if (c[i] === 1'b0) k = (k == -1) ? i : -2;
        end
        return k;
    endfunction : col_idx
    task automatic cmp(input logic [12:0] got, input logic [12:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic wr_at(input int a, input logic [CODE_W-1:0] d, input int slow);
        @(posedge sys_clk_i);
        shadow[a] <= d;
        host.wr(a[3:0], d, slow);
    endtask : wr_at
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////
    always @(posedge sys_clk_i) begin
        int k;
        k = col_idx(col_n);
        if (srst_i) begin
            per_cnt = -1;
        end else begin
            if (wr_d1 && wr_d2 && a_d1 == a_d2) cmp(seg_n, exp_seg(a_d1), "write");
            qcnt = wr ? 0 : qcnt + 1;
            on_cnt = dr_n ? on_cnt + 1 : 0;
            off_cnt = dr_n ? 0 : off_cnt + 1;
            if (off_cnt >= 4) cmp(col_n, '1, "blank");
            if (on_cnt >= 4 && k != -1) cmp(k == -2, 0, "one column");
            if (on_cnt >= 4 && k >= 0) begin
                if (last_col >= 0 && k != last_col) cmp(k, (last_col + 1) % NUM_STATES, "order");
                if (qcnt >= 4) cmp(seg_q, exp_seg(k), "segments");
                last_col = k;
            end
            if (sclk && !sclk_q) begin
                if (per_cnt >= 0) cmp(per_cnt, SC, "scan period");
                per_cnt = 0;
                hi_cnt = 0;
            end
            if (!sclk && sclk_q) cmp(hi_cnt, SP, "scan pulse");
            if (per_cnt >= 0) per_cnt++;
            if (sclk) hi_cnt++;
        end
        sclk_q = sclk;
        seg_q = seg_n;
        wr_d2 = wr_d1;
        wr_d1 = wr;
        a_d2 = a_d1;
        a_d1 = addr;
    end

    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        // fill every word, scan, then random rewrites with random strobe lengths
        for (int a = 0; a < 2 * RAM_WORDS; a++) begin
            lfsr = next_rand(lfsr);
            wr_at(a < RAM_WORDS ? a : lfsr[19:16], lfsr[7:0], lfsr[9:8] + 1);
            if (a == RAM_WORDS - 1) repeat (2 * NUM_STATES * SC) @(posedge sys_clk_i);
        end
        repeat (2 * NUM_STATES * SC) @(posedge sys_clk_i);
        dr_n <= 1'b0;
        repeat (3 * SC) @(posedge sys_clk_i);
        dr_n <= 1'b1;
        repeat (2 * NUM_STATES * SC) @(posedge sys_clk_i);
        key <= 1'b1;
        #1 cmp(irq, 0, "irq early");
        @(posedge sys_clk_i);
        #1 cmp(irq, 1, "irq set");
        @(posedge sys_clk_i);
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        key <= 1'b0;
        @(posedge sys_clk_i);
        #1 cmp(irq, 0, "irq cleared");
        @(posedge sys_clk_i);
        key <= 1'b1;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        #1 cmp(irq, 1, "set over clear");
        stop_test();
    end
endmodule : lmdsc_bench
